// ---- lcr_top.sv ----
// Command decoder and reset logic of a 33x96 dot-matrix display controller.
// Assumes host pins synchronous to ref_clk_i and an APB master for setup.
`timescale 1ns/1ps
`default_nettype none
`include "lcr_map.svh"
module lcr_top
	import lcr_pkg::*;
(
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        srst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Host microprocessor bus
	input  wire logic        hw_reset_n_i,
	input  wire logic        cmd_data_sel_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic [7:0]  data_i,
	output logic      [7:0]  data_o,
	output logic             data_oe_n_o,
	input  wire logic        sclk_i,
	input  wire logic        sdata_i,
	input  wire logic        cs_n_i,
	// Panel drive
	output logic             line_clock_out_o,
	output logic             frame_polarity_out_o,
	output logic             static_frame_out_o,
	output logic             display_off_n_out_o,
	output logic             osc_run_o,
	output logic             seg_com_vdd_o,
	output logic             drive_discharge_o,
	output logic             bias5_o
);
	// ==========================================================
	// Declarations
	lcr_core_t  s;
	lcr_core_t  next_s;
	lcr_hbus_if bus ();
	logic [7:0] mem_rd;
	logic       mem_we;
	logic [7:0] stat_b;
	logic [7:0] cmd;

	// ==========================================================
	// Helper functions

	// Column step that tops out at the last column, page untouched
	function automatic logic [7:0] col_inc(input logic [7:0] c);
		return (c >= `LCR_COL_MAX) ? c : c + 8'h01;
	endfunction

	// RAM word index from page and column
	function automatic logic [8:0] ram_addr(input logic [3:0] p, input logic [7:0] c);
		return 9'(9'(p) * `LCR_COLS + 9'(c));
	endfunction

	// Defaults shared by the reset command and the reset pin
	function automatic lcr_core_t soft_rst(input lcr_core_t x);
		lcr_core_t r;
		r            = x;
		r.rmw        = 1'b0;
		r.static_on  = 1'b0;
		r.static_reg = 2'h0;
		r.start      = 6'h00;
		r.col        = 8'h00;
		r.page       = 4'h0;
		r.com_rev    = 1'b0;
		r.rr_mode    = 1'b0;
		r.vol_mode   = 1'b0;
		r.volume     = `LCR_VOL_RST;
		r.test       = 1'b0;
		r.busy_cnt   = `LCR_RST_CYC;
		return r;
	endfunction

	// Full pin-reset defaults; APB setup is kept
	function automatic lcr_core_t hw_rst(input lcr_core_t x);
		lcr_core_t r;
		r          = soft_rst(x);
		r.disp_on  = 1'b0;
		r.reverse  = 1'b0;
		r.adc      = 1'b0;
		r.all_on   = 1'b0;
		r.psave    = 1'b0;
		r.pwr      = 3'h0;
		r.bias5    = x.duty17;
		r.line_div = 6'h00;
		r.line     = 6'h00;
		r.frame    = 1'b0;
		r.cl       = 1'b0;
		return r;
	endfunction

	// ==========================================================
	// Cycle decoder and display RAM
	lcr_bus_decoder u_dec (
		.ref_clk_i      (ref_clk_i),
		.srst_i         (srst_i),
		.hw_reset_n_i   (hw_reset_n_i),
		.mode_i         (s.mode),
		.cmd_data_sel_i (cmd_data_sel_i),
		.rd_n_i         (rd_n_i),
		.wr_n_i         (wr_n_i),
		.data_i         (data_i),
		.sclk_i         (sclk_i),
		.sdata_i        (sdata_i),
		.cs_n_i         (cs_n_i),
		.bus            (bus.src)
	);

	lcr_mem u_mem (
		.ref_clk_i (ref_clk_i),
		.we_i      (mem_we),
		.addr_i    (ram_addr(s.page, s.col)),
		.wdata_i   (bus.wdata),
		.rdata_o   (mem_rd)
	);

	// ==========================================================
	// Status byte: page address deliberately absent
	assign stat_b = {|s.busy_cnt, s.adc, !s.disp_on, |s.busy_cnt, 4'h0};
	assign cmd    = bus.wdata;
	assign mem_we = hw_reset_n_i && bus.wr_stb && bus.is_data;

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_s         = s;
		next_s.cl      = 1'b0;
		next_s.pslverr = 1'b0;

		// APB: answer prepared in setup, write lands in access phase
		if (psel_i && !penable_i && !pwrite_i) begin
			case (paddr_i)
				`LCR_A_CFG:  next_s.prdata = {29'h0, s.duty17, s.mode};
				`LCR_A_STAT: next_s.prdata = {2'h0, s.start, s.col, s.page,
					s.test, s.vol_mode, s.rr_mode, s.com_rev, s.rmw, s.static_on,
					s.bias5, s.psave, s.all_on, s.adc, s.reverse, s.disp_on};
				`LCR_A_SET:  next_s.prdata = {13'h0, stat_b, s.static_reg,
					s.pwr, s.volume};
				default: begin
					next_s.prdata  = 32'h0;
					next_s.pslverr = 1'b1;
				end
			endcase
		end else if (psel_i && !penable_i) begin
			next_s.pslverr = (paddr_i != `LCR_A_CFG) && (paddr_i != `LCR_A_STAT)
				&& (paddr_i != `LCR_A_SET);
		end else if (psel_i && penable_i) begin
			next_s.pslverr = s.pslverr;
		end
		if (psel_i && penable_i && pwrite_i && paddr_i == `LCR_A_CFG) begin
			next_s.mode   = lcr_mode_t'(pwdata_i[1:0]);
			next_s.duty17 = pwdata_i[2];
		end

		// Reset-in-progress countdown
		if (s.busy_cnt != 4'h0) begin
			next_s.busy_cnt = s.busy_cnt - 4'h1;
		end

		// Display timing: line strobe and frame polarity
		if (s.line_div == 6'(`LCR_LINE_CYC - 6'h01)) begin
			next_s.line_div = 6'h00;
			next_s.cl       = 1'b1;
			if (s.line == 6'((s.duty17 ? `LCR_LINES17 : `LCR_LINES33) - 6'h01)) begin
				next_s.line  = 6'h00;
				next_s.frame = !s.frame;
			end else begin
				next_s.line = s.line + 6'h01;
			end
		end else begin
			next_s.line_div = s.line_div + 6'h01;
		end

		// Data accesses move the column; read-modify-write freezes reads
		if (bus.rd_stb) begin
			next_s.dout = bus.is_data ? mem_rd : stat_b;
			if (bus.is_data && !s.rmw) begin
				next_s.col = col_inc(s.col);
			end
		end
		if (bus.wr_stb && bus.is_data) begin
			next_s.col = col_inc(s.col);
		end

		// Command interpretation; unmatched codes fall through untouched
		if (bus.wr_stb && !bus.is_data) begin
			if (cmd[7:1] == `LCR_C_DISP) begin
				next_s.disp_on = cmd[0];
				if (!cmd[0] && s.all_on) begin
					next_s.psave = 1'b1;
				end else if (cmd[0]) begin
					next_s.psave = 1'b0;
				end
			end else if (cmd[7:1] == `LCR_C_ADC) begin
				next_s.adc = cmd[0];
			end else if (cmd[7:1] == `LCR_C_REV) begin
				next_s.reverse = cmd[0];
			end else if (cmd[7:1] == `LCR_C_ALLON) begin
				next_s.all_on = cmd[0];
				if (cmd[0] && !s.disp_on) begin
					next_s.psave = 1'b1;
				end else if (!cmd[0]) begin
					next_s.psave = 1'b0;
				end
			end else if (cmd[7:1] == `LCR_C_BIAS) begin
				next_s.bias5 = cmd[0];
			end else if (cmd == `LCR_C_RMW) begin
				next_s.rmw     = 1'b1;
				next_s.rmw_col = s.col;
			end else if (cmd == `LCR_C_END) begin
				next_s.rmw = 1'b0;
				if (s.rmw) begin
					next_s.col = s.rmw_col;
				end
			end else if (cmd == `LCR_C_RESET) begin
				next_s = soft_rst(next_s);
			end else if (cmd[7:6] == `LCR_P_START) begin
				next_s.start = cmd[5:0];
			end else if (cmd[7:4] == `LCR_P_PAGE) begin
				if (cmd[3:0] <= `LCR_PAGE_MAX) begin
					next_s.page = cmd[3:0];
				end
			end else if (cmd[7:4] == `LCR_P_COLH) begin
				next_s.col = {cmd[3:0], s.col[3:0]};
			end else if (cmd[7:4] == `LCR_P_COLL) begin
				next_s.col = {s.col[7:4], cmd[3:0]};
			end
		end

		// Pin reset wins over everything the host bus did this cycle except a read loading dout
		if (!hw_reset_n_i) begin
			next_s = hw_rst(next_s);
		end
		if (srst_i) begin
			next_s = hw_rst(lcr_core_t'('0));
		end
	end

	// State register
	always_ff @(posedge ref_clk_i) begin
		s <= next_s;
	end

	// ==========================================================
	// Outputs
	assign prdata_o    = s.prdata;
	assign pready_o    = 1'b1;
	assign pslverr_o   = s.pslverr && psel_i && penable_i;
	assign data_o      = s.dout;
	assign bias5_o     = s.bias5;

	// Bus drive follows the read strobe; the reset pin leaves it alone
	assign data_oe_n_o = !((s.mode == MODE_PAIR && !rd_n_i)
		|| (s.mode == MODE_ENA && rd_n_i && wr_n_i));

	// Held high at once while the pin is low (osc_run_o low), no clock lag
	assign line_clock_out_o     = !hw_reset_n_i || s.cl;
	assign frame_polarity_out_o = !hw_reset_n_i || s.frame;
	assign static_frame_out_o   = !hw_reset_n_i || (s.static_on && s.frame);
	assign display_off_n_out_o  = !hw_reset_n_i || s.disp_on;
	assign osc_run_o            = hw_reset_n_i;
	assign seg_com_vdd_o        = !hw_reset_n_i;
	assign drive_discharge_o    = !hw_reset_n_i;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	sequence cmd_seq(logic [7:0] code);
		hw_reset_n_i && bus.wr_stb && !bus.is_data && cmd == code;
	endsequence

	AST_HW_DEF: assert property (!hw_reset_n_i |=> !s.disp_on && !s.reverse
		&& !s.adc && !s.all_on && !s.psave && s.pwr == 3'h0)
		else $error("pin reset left a display setting");
	AST_BIAS: assert property (!hw_reset_n_i |=> s.bias5 == s.duty17)
		else $error("bias not taken from duty strap");
	AST_VOL: assert property (!hw_reset_n_i |=> s.volume == `LCR_VOL_RST
		&& !s.static_on && s.static_reg == 2'h0 && !s.rr_mode && !s.vol_mode)
		else $error("volume or indicator not reset");
	AST_ADDR: assert property (!hw_reset_n_i |=> s.start == 6'h00
		&& s.col == 8'h00 && s.page == 4'h0 && !s.rmw && !s.test && !s.com_rev)
		else $error("addresses not reset");
	AST_SOFT: assert property (cmd_seq(`LCR_C_RESET) |=> s.col == 8'h00
		&& s.disp_on == $past(s.disp_on) && s.adc == $past(s.adc))
		else $error("reset command touched the wrong settings");
	AST_PINS: assert property (!hw_reset_n_i |-> line_clock_out_o
		&& frame_polarity_out_o && static_frame_out_o && display_off_n_out_o
		&& !osc_run_o && seg_com_vdd_o && drive_discharge_o)
		else $error("panel pins not parked during reset");
	AST_DISP: assert property (hw_reset_n_i && bus.wr_stb && !bus.is_data
		&& cmd[7:1] == `LCR_C_DISP |=> s.disp_on == $past(cmd[0]))
		else $error("display on/off command not applied");
	AST_PSAVE: assert property (cmd_seq({`LCR_C_DISP, 1'b0}) ##0 s.all_on
		|=> s.psave)
		else $error("power save not entered");
	AST_START: assert property (hw_reset_n_i && bus.wr_stb && !bus.is_data
		&& cmd[7:6] == `LCR_P_START |=> s.start == $past(cmd[5:0]))
		else $error("start line not loaded");
	AST_COLSAT: assert property (hw_reset_n_i && mem_we
		&& s.col == `LCR_COL_MAX |=> s.col == `LCR_COL_MAX && s.page == $past(s.page))
		else $error("column wrapped past the top");
	AST_BUSY: assert property ($rose(hw_reset_n_i) |-> stat_b[4] [*8])
		else $error("reset flag dropped too early");
endmodule // lcr_top
`default_nettype wire

// ---- lcr_map.svh ----
// Constants of the display command decoder: offsets, fields, resets, timing.
// Assumes inclusion by the package and by every design file that needs a number.
`ifndef LCR_MAP_SVH
`define LCR_MAP_SVH

// ==========================================================
// APB register offsets
`define LCR_A_CFG      8'h00
`define LCR_A_STAT     8'h04
`define LCR_A_SET      8'h08

// ==========================================================
// Command codes and prefixes
`define LCR_C_DISP     7'h57
`define LCR_C_ADC      7'h50
`define LCR_C_BIAS     7'h51
`define LCR_C_ALLON    7'h52
`define LCR_C_REV      7'h53
`define LCR_C_RMW      8'hE0
`define LCR_C_END      8'hEE
`define LCR_C_RESET    8'hE2
`define LCR_P_START    2'h1
`define LCR_P_PAGE     4'hB
`define LCR_P_COLH     4'h1
`define LCR_P_COLL     4'h0

// ==========================================================
// Reset values and limits
`define LCR_VOL_RST    6'h20
`define LCR_COL_MAX    8'h5F
`define LCR_PAGE_MAX   4'h4
`define LCR_COLS       9'h060
`define LCR_RAM_WORDS  480
`define LCR_LINES33    6'h21
`define LCR_LINES17    6'h11

// ==========================================================
// Timing
`define LCR_CLK_NS     100
`define LCR_RST_NS     1000
`define LCR_RST_CYC    4'((`LCR_RST_NS + `LCR_CLK_NS - 1) / `LCR_CLK_NS)
`define LCR_LINE_NS    3200
`define LCR_LINE_CYC   6'(`LCR_LINE_NS / `LCR_CLK_NS)

`endif

// ---- lcr_pkg.sv ----
// Types shared by the display command decoder modules.
// Assumes lcr_map.svh is on the include path.
`default_nettype none
`include "lcr_map.svh"
package lcr_pkg;
	typedef enum logic [1:0] {MODE_PAIR, MODE_ENA, MODE_SER} lcr_mode_t;

	typedef struct packed {
		logic [`LCR_RAM_WORDS-1:0][7:0] m;
		logic [7:0]                     rd;
	} lcr_mem_t;

	typedef struct packed {
		logic       rd_q, wr_q, sclk_q;
		logic [7:0] sh;
		logic [2:0] cnt;
		logic       wr_stb, rd_stb, is_data;
		logic [7:0] wdata;
	} lcr_dec_t;

	typedef struct packed {
		lcr_mode_t   mode;
		logic        duty17;
		logic        disp_on, reverse, adc, all_on, psave, bias5;
		logic [2:0]  pwr;
		logic        static_on;
		logic [1:0]  static_reg;
		logic        rmw;
		logic [7:0]  rmw_col;
		logic [5:0]  start;
		logic [7:0]  col;
		logic [3:0]  page;
		logic        com_rev, rr_mode, vol_mode, test;
		logic [5:0]  volume;
		logic [3:0]  busy_cnt;
		logic [7:0]  dout;
		logic [5:0]  line_div, line;
		logic        frame, cl;
		logic [31:0] prdata;
		logic        pslverr;
	} lcr_core_t;
endpackage
`default_nettype wire

// ---- lcr_hbus_if.sv ----
// Decoded host bus accesses passed from the cycle decoder to the core.
// Assumes one clock; strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface lcr_hbus_if;
	logic       wr_stb;
	logic       rd_stb;
	logic       is_data;
	logic [7:0] wdata;
	modport src (output wr_stb, rd_stb, is_data, wdata);
	modport snk (input wr_stb, rd_stb, is_data, wdata);
endinterface
`default_nettype wire

// ---- lcr_mem.sv ----
// Display data RAM: five pages of 96 bytes, one address shared by write and read.
// Assumes addresses below 480; read data registered one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "lcr_map.svh"
module lcr_mem
	import lcr_pkg::*;
(
	// Clock
	input  wire logic       ref_clk_i,
	// Ports
	input  wire logic       we_i,
	input  wire logic [8:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic      [7:0] rdata_o
);
	lcr_mem_t s;
	lcr_mem_t next_s;

	// Out-of-range addresses neither write nor read
	always_comb begin
		next_s = s;
		if (we_i && addr_i < 9'(`LCR_RAM_WORDS)) begin
			next_s.m[addr_i] = wdata_i;
		end
		next_s.rd = (addr_i < 9'(`LCR_RAM_WORDS)) ? s.m[addr_i] : 8'h00;
	end

	// Contents survive every reset
	always_ff @(posedge ref_clk_i) begin
		s <= next_s;
	end

	assign rdata_o = s.rd;
endmodule // lcr_mem
`default_nettype wire

// ---- lcr_bus_decoder.sv ----
// Host bus cycle decoder: strobe-pair, enable-strobe and serial modes.
// Assumes pins synchronous to ref_clk_i and pulses of two clocks or more.
`timescale 1ns/1ps
`default_nettype none
module lcr_bus_decoder
	import lcr_pkg::*;
(
	// Clock and resets
	input  wire logic       ref_clk_i,
	input  wire logic       srst_i,
	input  wire logic       hw_reset_n_i,
	// Mode and pins
	input  wire lcr_mode_t  mode_i,
	input  wire logic       cmd_data_sel_i,
	input  wire logic       rd_n_i,
	input  wire logic       wr_n_i,
	input  wire logic [7:0] data_i,
	input  wire logic       sclk_i,
	input  wire logic       sdata_i,
	input  wire logic       cs_n_i,
	// Decoded accesses
	lcr_hbus_if.src         bus
);
	lcr_dec_t s;
	lcr_dec_t next_s;

	// Edge detection on the strobes; data taken at the closing edge
	always_comb begin
		next_s        = s;
		next_s.wr_stb = 1'b0;
		next_s.rd_stb = 1'b0;
		next_s.rd_q   = rd_n_i;
		next_s.wr_q   = wr_n_i;
		next_s.sclk_q = sclk_i;
		case (mode_i)
			MODE_PAIR: begin
				if (!s.wr_q && wr_n_i) begin
					next_s.wr_stb  = 1'b1;
					next_s.is_data = cmd_data_sel_i;
					next_s.wdata   = data_i;
				end
				if (s.rd_q && !rd_n_i) begin
					next_s.rd_stb  = 1'b1;
					next_s.is_data = cmd_data_sel_i;
				end
			end
			MODE_ENA: begin
				// Read opens at the rising enable so data stands while it is high
				if (!s.rd_q && rd_n_i && wr_n_i) begin
					next_s.rd_stb  = 1'b1;
					next_s.is_data = cmd_data_sel_i;
				end
				if (s.rd_q && !rd_n_i && !wr_n_i) begin
					next_s.wr_stb  = 1'b1;
					next_s.is_data = cmd_data_sel_i;
					next_s.wdata   = data_i;
				end
			end
			MODE_SER: begin
				if (cs_n_i) begin
					next_s.cnt = 3'h0;
				end else if (!s.sclk_q && sclk_i) begin
					next_s.sh  = {s.sh[6:0], sdata_i};
					next_s.cnt = s.cnt + 3'h1;
					if (s.cnt == 3'h7) begin
						next_s.wr_stb  = 1'b1;
						next_s.is_data = cmd_data_sel_i;
						next_s.wdata   = {s.sh[6:0], sdata_i};
					end
				end
			end
			default: begin
				next_s.cnt = 3'h0;
			end
		endcase
		if (srst_i || !hw_reset_n_i) begin
			next_s        = '0;
			next_s.rd_q   = rd_n_i;
			next_s.wr_q   = wr_n_i;
			next_s.sclk_q = sclk_i;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i) begin
		s <= next_s;
	end

	assign bus.wr_stb  = s.wr_stb;
	assign bus.rd_stb  = s.rd_stb;
	assign bus.is_data = s.is_data;
	assign bus.wdata   = s.wdata;

	AST_SER_LAST: assert property (@(posedge ref_clk_i) disable iff (srst_i)
		(mode_i == MODE_SER && next_s.wr_stb) |=> s.wdata[0] == $past(sdata_i))
		else $error("serial byte not closed by its last bit");
endmodule // lcr_bus_decoder
`default_nettype wire

// ---- lcr_host_model.sv ----
// Host processor model driving the parallel, enable-strobe and serial pins.
// Assumes its tasks are called one at a time from a single bench process.
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model (
	// Clock
	input  wire logic       clk_i,
	// Host pins
	output logic            hw_reset_n_o,
	output logic            sel_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic      [7:0] data_o,
	output logic            sclk_o,
	output logic            sdata_o,
	output logic            cs_n_o,
	input  wire logic [7:0] data_i
);
	// ==========================================================
	// Idle levels; the device state is unknown until the pin reset
	initial begin
		hw_reset_n_o = 1'b0;
		sel_o = 1'b0;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		data_o = 8'h00;
		sclk_o = 1'b0;
		sdata_o = 1'b0;
		cs_n_o = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Pin reset level, held two edges
	task automatic rst_pin(input logic v);
		hw_reset_n_o <= v;
		tick(2);
	endtask

	// Idle strobes: enable mode keeps its enable low and direction at read
	task automatic idle(input logic ena);
		rd_n_o <= !ena;
		wr_n_o <= 1'b1;
		tick(4);
	endtask

	// Write one byte; enable mode uses rd_n as enable and wr_n as direction
	task automatic wr(input logic ena, input logic sel, input logic [7:0] b);
		sel_o <= sel;
		data_o <= b;
		wr_n_o <= 1'b0;
		if (ena) begin
			tick(1);
			rd_n_o <= 1'b1;
			tick(2);
			rd_n_o <= 1'b0;
		end else begin
			tick(2);
			wr_n_o <= 1'b1;
		end
		tick(1);
		wr_n_o <= 1'b1;
		data_o <= ~b; // Released bus must not keep the last byte
		tick(4);
	endtask

	// Strobe-pair read
	task automatic rd(input logic sel, output logic [7:0] b);
		sel_o <= sel;
		rd_n_o <= 1'b0;
		tick(3);
		b = data_i;
		rd_n_o <= 1'b1;
		tick(4);
	endtask

	// Serial byte; clock stands still outside the frame
	task automatic ser(input logic sel, input logic [7:0] b);
		sel_o <= sel;
		cs_n_o <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			sdata_o <= b[i];
			sclk_o <= 1'b0;
			tick(2);
			sclk_o <= 1'b1;
			tick(2);
		end
		sclk_o <= 1'b0;
		tick(2);
		cs_n_o <= 1'b1;
		sdata_o <= ~b[0];
		tick(4);
	endtask
endmodule // lcr_host_model
`default_nettype wire

// ---- tb_lcd_command_reset_decoder.sv ----
// Self-checking bench of the display command decoder and reset logic.
// Assumes lcr_map.svh on the include path and lcr_host_model as host.
`timescale 1ns/1ps
`default_nettype none
`include "lcr_map.svh"
module tb_lcd_command_reset_decoder;
	import lcr_pkg::*;
	// ==========================================================
	// Signals
	logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, hdata, ddata;
	logic [31:0] pwdata, prdata;
	logic        hrst_n, hsel, rd_n, wr_n, sclk, sdata, cs_n;
	logic        lclk, frm, sfrm, doff_n, osc, scv, dis, bias5, oe_n;
	int          err_total, samples_checked, cycles;

	lcr_top dut (.ref_clk_i(ref_clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .hw_reset_n_i(hrst_n),
		.cmd_data_sel_i(hsel), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(hdata),
		.data_o(ddata), .data_oe_n_o(oe_n), .sclk_i(sclk), .sdata_i(sdata), .cs_n_i(cs_n),
		.line_clock_out_o(lclk), .frame_polarity_out_o(frm), .static_frame_out_o(sfrm),
		.display_off_n_out_o(doff_n), .osc_run_o(osc), .seg_com_vdd_o(scv),
		.drive_discharge_o(dis), .bias5_o(bias5));
	lcr_host_model host (.clk_i(ref_clk), .hw_reset_n_o(hrst_n), .sel_o(hsel),
		.rd_n_o(rd_n), .wr_n_o(wr_n), .data_o(hdata), .sclk_o(sclk), .sdata_o(sdata),
		.cs_n_o(cs_n), .data_i(ddata));

	// ==========================================================
	// Clock and hang guard
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// APB transfer held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic stat(output logic [31:0] v);
		logic e;
		apb(1'b0, `LCR_A_STAT, 32'h0, v, e);
	endtask

	// Pin reset; panel pins high (osc low) while low, then busy, then idle status
	task automatic pin_reset();
		logic [7:0] b;
		host.rst_pin(1'b0);
		chk("panel", 32'({lclk, frm, sfrm, doff_n, osc, scv, dis, oe_n}), 32'hF7);
		host.rst_pin(1'b1);
		host.rd(1'b0, b);
		chk("busy", 32'(b), 32'hB0);
		host.rd(1'b0, b);
		chk("idle", 32'(b), 32'h20);
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_defaults();
		logic [31:0] v;
		logic        e;
		pin_reset();
		stat(v);
		chk("stat_rst", v, 32'h0);
		apb(1'b0, `LCR_A_SET, 32'h0, v, e);
		chk("set_rst", v, 32'h00010020);
		apb(1'b0, 8'h0C, 32'h0, v, e);
		chk("unmapped", 32'(e), 32'h1);
	endtask

	task automatic t_display();
		logic [31:0] v;
		logic [7:0]  b;
		host.wr(1'b0, 1'b0, {`LCR_C_DISP, 1'b1});
		stat(v);
		host.rd(1'b0, b);
		chk("on", {v[0], 23'h0, b}, 32'h80000000);
		host.wr(1'b0, 1'b0, {`LCR_C_ALLON, 1'b1});
		host.wr(1'b0, 1'b0, {`LCR_C_DISP, 1'b0});
		stat(v);
		chk("psave", 32'(v[4:0]), 32'h18);
		host.wr(1'b0, 1'b0, {`LCR_C_ALLON, 1'b0});
	endtask

	task automatic t_address();
		logic [31:0] v, w;
		logic [7:0]  s0, s1, b;
		host.wr(1'b0, 1'b0, 8'h5F);
		host.wr(1'b0, 1'b0, 8'hB2);
		host.rd(1'b0, s0);
		host.wr(1'b0, 1'b0, 8'hB4);
		host.rd(1'b0, s1);
		chk("stat_pg", 32'(s1), 32'(s0));
		// Page five is out of range and must leave page four in place
		host.wr(1'b0, 1'b0, 8'hB5);
		host.wr(1'b0, 1'b0, 8'h15);
		host.wr(1'b0, 1'b0, 8'h0E);
		stat(v);
		chk("addr", 32'(v[29:12]), 32'h1F5E4);
		host.wr(1'b0, 1'b1, 8'h3C);
		host.wr(1'b0, 1'b1, 8'hC3);
		stat(v);
		chk("sat", 32'(v[23:12]), 32'h5F4);
		host.wr(1'b0, 1'b0, 8'h15);
		host.wr(1'b0, 1'b0, 8'h0E);
		// Reads come straight from the addressed word, so no dummy read here
		host.rd(1'b1, b);
		chk("ram", 32'(b), 32'h3C);
		host.rd(1'b1, b);
		chk("ram_top", 32'(b), 32'hC3);
		stat(v);
		host.wr(1'b0, 1'b0, 8'hA8);
		stat(w);
		chk("unknown", w, v);
	endtask

	task automatic t_softreset();
		logic [31:0] v;
		host.wr(1'b0, 1'b0, {`LCR_C_ADC, 1'b1});
		host.wr(1'b0, 1'b0, `LCR_C_RESET);
		host.tick(12);
		stat(v);
		chk("soft", v, 32'h4);
	endtask

	task automatic t_modes();
		logic [31:0] v;
		logic        e;
		host.idle(1'b1);
		apb(1'b1, `LCR_A_CFG, 32'h1, v, e);
		host.wr(1'b1, 1'b0, {`LCR_C_DISP, 1'b1});
		stat(v);
		chk("ena", 32'(v[0]), 32'h1);
		host.idle(1'b0);
		apb(1'b1, `LCR_A_CFG, 32'h2, v, e);
		host.ser(1'b0, {`LCR_C_DISP, 1'b0});
		host.ser(1'b0, {`LCR_C_BIAS, 1'b1});
		stat(v);
		chk("ser", 32'({v[5], v[0], bias5}), 32'h5);
		// Mode three decodes no host bus at all
		apb(1'b1, `LCR_A_CFG, 32'h3, v, e);
		host.wr(1'b0, 1'b0, {`LCR_C_DISP, 1'b1});
		stat(v);
		chk("none", 32'(v[0]), 32'h0);
	endtask

	task automatic t_hwreset();
		logic [31:0] v;
		logic        e;
		for (int d = 0; d < 2; d++) begin
			apb(1'b1, `LCR_A_CFG, 32'(d * 4), v, e);
			pin_reset();
			stat(v);
			chk("hw_stat", v, 32'(d * 32));
			chk("bias", 32'(bias5), 32'(d));
			apb(1'b0, `LCR_A_CFG, 32'h0, v, e);
			chk("cfg", 32'(v[2:0]), 32'(d * 4));
		end
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		ref_clk = 1'b0;
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_total = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		t_defaults();
		t_display();
		t_address();
		t_softreset();
		t_modes();
		t_hwreset();
		conclude();
	end
endmodule // tb_lcd_command_reset_decoder
`default_nettype wire
